// [rtl/cfw_clock_ctrl.sv]
/*
 Clock reference selection, varispeed, pitch hold and time code
 freewheel control, with its register port and interrupt.
 Assumes reference presence levels come from pin detectors, while
 ext_rate and frame_tick come from logic on clk.
*/
`timescale 1ns/1ps
module cfw_clock_ctrl
	import cfw_pkg::*;
#(
	parameter int BLINK_CYC = CFW_BLINK_CYC // Lamp half period, cycles.
)
(
	input  logic        clk,           // System clock, 10 MHz.
	input  logic        resetn,        // Asynchronous reset, low.
	input  logic [7:0]  addr,          // Register byte address.
	input  logic [31:0] wdata,         // Write data.
	input  logic        wr,            // Write strobe.
	input  logic        rd,            // Read strobe.
	output logic [31:0] rdata,         // Read data, cycle after rd.
	output logic        irq,           // Level interrupt.
	input  logic        ltc_present,   // LTC input detected.
	input  logic        vref_present,  // Black burst on video ref.
	input  logic        vin_present,   // Picture on video input.
	input  logic        aes_present,   // AES clock detected.
	input  logic        wclk_present,  // Word clock detected.
	input  logic        nv_pitch_hold, // Stored pitch hold value.
	input  logic [17:0] ext_rate,      // Measured external rate, Hz.
	input  logic        frame_tick,    // One pulse per frame.
	output logic        nv_wr,         // Store pitch hold pulse.
	output logic        nv_data,       // Pitch hold value to store.
	output logic        wclk_xtal,     // Word clock from crystal.
	output logic        aes_xtal,      // AES clock from crystal.
	output logic        tc_xtal,       // Generated code on crystal.
	output logic [17:0] out_rate,      // Output sample rate, Hz.
	output logic        tc_gen_en,     // Time code generation on.
	output logic        vitc_read_en,  // VITC reader enabled.
	output logic        lock_led       // Lock lamp drive.
);
	logic [5:0]        pres;
	logic [2:0]        clk_ref;
	logic [1:0]        pos_ref;
	logic [2:0]        rate_sel;
	logic signed [2:0] ed_semis;
	logic signed [6:0] ed_cents;
	logic              ed_vso;
	logic signed [2:0] vso_semis;
	logic signed [6:0] vso_cents;
	logic              vso_on;
	logic              pitch_ed;
	logic              pitch_hold;
	logic [5:0]        free_ed;
	logic [5:0]        freewheel_length_setting;
	logic [1:0]        boot;
	logic [2:0]        ridx;
	logic [1:0]        cls;
	logic [17:0]       nominal;
	logic [17:0]       lim_lo;
	logic [17:0]       lim_hi;
	logic [17:0]       next_rate;
	logic              ref_ok;
	logic              cfg_ok;
	logic              locked;
	logic              locked_q;
	logic              rng;
	logic              range_err;
	logic              tc_in_ok;
	logic              gen_mode;
	cfw_fw_t           fw_st;
	logic [5:0]        fw_cnt;
	logic              fw_exp;
	logic [21:0]       blink_cnt;
	logic              blink;
	logic [2:0]        ev;
	logic [2:0]        istat;
	logic [2:0]        imask;
	logic              wr_apply;

	cfw_vso_if vso ();

	cfw_sync #(.W(6)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({nv_pitch_hold, wclk_present, aes_present, vin_present,
			vref_present, ltc_present}),
		.q      (pres)
	);

	cfw_vso_calc u_vso (
		.clk    (clk),
		.resetn (resetn),
		.vso    (vso.calc)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////
	// Register writes.

	assign wr_apply = wr && addr == CFW_A_APPLY;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clk_ref  <= CFW_CR_INT;
			pos_ref  <= CFW_PR_GEN;
			rate_sel <= 3'h0;
			imask    <= 3'h0;
		end
		else if (wr && addr == CFW_A_CTRL)
		begin
			clk_ref  <= wdata[CFW_F_CLK +: 3];
			pos_ref  <= wdata[CFW_F_POS +: 2];
			rate_sel <= wdata[CFW_F_RATE +: 3];
		end
		else if (wr && addr == CFW_A_IMASK)
			imask <= wdata[2:0];
	end

	// Varispeed edits are staged here and only reach the clock when
	// the set command arrives, so a half typed value never plays.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ed_semis  <= '0;
			ed_cents  <= '0;
			ed_vso    <= 1'b0;
			vso_semis <= '0;
			vso_cents <= '0;
			vso_on    <= 1'b0;
		end
		else if (wr && addr == CFW_A_VSO)
		begin
			ed_cents <= wdata[CFW_F_CENT +: 7];
			ed_semis <= wdata[CFW_F_SEMI +: 3];
			ed_vso   <= wdata[CFW_F_VEN];
		end
		else if (wr_apply && wdata[CFW_B_VSO])
		begin
			vso_semis <= ed_semis;
			vso_cents <= ed_cents;
			vso_on    <= ed_vso;
		end
	end

	// Freewheel length only steps within its range.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			free_ed  <= CFW_FW_MIN;
			freewheel_length_setting <= CFW_FW_MIN;
		end
		else if (wr && addr == CFW_A_FREE)
		begin
			if (wdata[CFW_B_UP] && free_ed < CFW_FW_MAX)
				free_ed <= free_ed + 6'h01;
			else if (wdata[CFW_B_DN] && free_ed > CFW_FW_MIN)
				free_ed <= free_ed - 6'h01;
		end
		else if (wr_apply && wdata[CFW_B_FREE])
			freewheel_length_setting <= free_ed;
	end

	fw_range_a: assert property (freewheel_length_setting >= CFW_FW_MIN
		&& freewheel_length_setting <= CFW_FW_MAX)
		else $error("freewheel length left its range");

	////////////////////////////////////////////////////////////////////
	// Pitch hold and its non-volatile copy.

	// The stored value is taken once the synchroniser has settled.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			boot       <= 2'h0;
			pitch_ed   <= 1'b0;
			pitch_hold <= 1'b0;
			nv_wr      <= 1'b0;
			nv_data    <= 1'b0;
		end
		else
		begin
			nv_wr <= 1'b0;
			if (boot != 2'h3)
				boot <= boot + 2'h1;
			if (boot == 2'h2)
			begin
				pitch_hold <= pres[5];
				pitch_ed   <= pres[5];
			end
			else if (wr && addr == CFW_A_PITCH)
				pitch_ed <= wdata[0];
			else if (wr_apply && wdata[CFW_B_PHLD])
			begin
				pitch_hold <= pitch_ed;
				nv_wr      <= 1'b1;
				nv_data    <= pitch_ed;
			end
		end
	end

	pitch_set_a: assert property (boot == 2'h3 && !wr_apply
		|=> $stable(pitch_hold))
		else $error("pitch hold changed without set");

	////////////////////////////////////////////////////////////////////
	// Reference status and output rate.

	always_comb
	begin
		ridx    = rate_sel > CFW_RATE_MAX ? 3'h0 : rate_sel;
		cls     = ridx[2:1];
		nominal = CFW_NOM[ridx];
		lim_lo  = CFW_LO[cls];
		lim_hi  = CFW_HI[cls];
		case (clk_ref)
			CFW_CR_INT:  ref_ok = 1'b1;
			CFW_CR_LTC:  ref_ok = pres[0];
			CFW_CR_VREF: ref_ok = pres[1];
			CFW_CR_VIN:  ref_ok = pres[2];
			CFW_CR_AES:  ref_ok = pres[3];
			CFW_CR_WCLK: ref_ok = pres[4];
			default:     ref_ok = 1'b0;
		endcase
		cfg_ok = clk_ref <= CFW_CR_WCLK && rate_sel <= CFW_RATE_MAX
			&& pos_ref != 2'h3;
		locked = cfg_ok && ref_ok;
		rng = vso_on && (vso.freq < lim_lo || vso.freq > lim_hi);
	end

	assign vso.nominal = nominal;
	assign vso.semis   = vso_semis;
	assign vso.cents   = vso_cents;

	always_comb
	begin
		if (clk_ref == CFW_CR_INT)
			next_rate = vso_on ? vso.freq : nominal;
		else if (ref_ok)
			next_rate = ext_rate;
		else if (pitch_hold)
			next_rate = out_rate;
		else
			next_rate = nominal;
		if (next_rate < lim_lo)
			next_rate = lim_lo;
		else if (next_rate > lim_hi)
			next_rate = lim_hi;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			out_rate  <= CFW_RATE_RST;
			range_err <= 1'b0;
			locked_q  <= 1'b1;
			wclk_xtal <= 1'b1;
			aes_xtal  <= 1'b1;
			tc_xtal   <= 1'b1;
		end
		else
		begin
			out_rate  <= next_rate;
			range_err <= rng;
			locked_q  <= locked;
			wclk_xtal <= clk_ref == CFW_CR_INT;
			aes_xtal  <= clk_ref == CFW_CR_INT;
			tc_xtal   <= clk_ref == CFW_CR_INT
				&& pos_ref == CFW_PR_GEN;
		end
	end

	xtal_both_a: assert property (clk_ref == CFW_CR_INT
		|=> wclk_xtal && aes_xtal)
		else $error("crystal not driving both clock outputs");
	tc_xtal_a: assert property (clk_ref == CFW_CR_INT
		&& pos_ref == CFW_PR_GEN |=> tc_xtal)
		else $error("generated code not on crystal");
	rate_lim_a: assert property ($stable(rate_sel)
		|-> out_rate >= lim_lo && out_rate <= lim_hi)
		else $error("output rate outside class limits");
	range_flag_a: assert property (vso_on && vso.freq > lim_hi
		|=> range_err)
		else $error("varispeed overrange not flagged");
	hold_rate_a: assert property (clk_ref != CFW_CR_INT && !ref_ok
		&& pitch_hold && $stable(rate_sel) |=> $stable(out_rate))
		else $error("held rate moved");
	nominal_a: assert property (clk_ref != CFW_CR_INT && !ref_ok
		&& !pitch_hold |=> out_rate == $past(nominal))
		else $error("lost reference did not return to nominal");

	////////////////////////////////////////////////////////////////////
	// Time code freewheel.

	always_comb
	begin
		gen_mode = pos_ref == CFW_PR_GEN;
		tc_in_ok = (pos_ref == CFW_PR_LTC && pres[0])
			|| (pos_ref == CFW_PR_VITC && pres[2]);
		fw_exp = fw_st == CFW_FW_FREE && !tc_in_ok && frame_tick
			&& fw_cnt + 6'h01 >= freewheel_length_setting;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fw_st  <= CFW_FW_STOP;
			fw_cnt <= 6'h00;
		end
		else if (gen_mode)
			fw_st <= CFW_FW_STOP;
		else
		begin
			case (fw_st)
				CFW_FW_RUN:
					if (!tc_in_ok)
					begin
						fw_st  <= CFW_FW_FREE;
						fw_cnt <= 6'h00;
					end
				CFW_FW_FREE:
					if (tc_in_ok)
						fw_st <= CFW_FW_RUN;
					else if (frame_tick)
					begin
						fw_cnt <= fw_cnt + 6'h01;
						if (fw_exp)
							fw_st <= CFW_FW_STOP;
					end
				CFW_FW_STOP:
					if (tc_in_ok)
						fw_st <= CFW_FW_RUN;
				default:
					fw_st <= CFW_FW_STOP;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tc_gen_en    <= 1'b1;
			vitc_read_en <= 1'b0;
		end
		else
		begin
			tc_gen_en    <= gen_mode || fw_st != CFW_FW_STOP;
			vitc_read_en <= pos_ref == CFW_PR_VITC && pres[2];
		end
	end

	sequence fw_back_s;
		fw_st == CFW_FW_FREE && tc_in_ok && !gen_mode;
	endsequence
	sequence fw_end_s;
		fw_st == CFW_FW_FREE && fw_exp && !gen_mode;
	endsequence
	fw_restore_a: assert property (fw_back_s |=>
		fw_st == CFW_FW_RUN)
		else $error("freewheel kept on after input returned");
	fw_expire_a: assert property (fw_end_s |=> fw_st == CFW_FW_STOP
		##1 !tc_gen_en)
		else $error("freewheel ran past its length");
	vitc_a: assert property (pos_ref == CFW_PR_VITC && pres[2]
		|=> vitc_read_en)
		else $error("VITC reader off with picture present");

	////////////////////////////////////////////////////////////////////
	// Lock lamp: steady when locked, flashing otherwise.

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			blink_cnt <= '0;
			blink     <= 1'b0;
			lock_led  <= 1'b0;
		end
		else
		begin
			if (blink_cnt == 22'(BLINK_CYC - 1))
			begin
				blink_cnt <= '0;
				blink     <= !blink;
			end
			else
				blink_cnt <= blink_cnt + 22'h1;
			lock_led <= locked || blink;
		end
	end

	led_a: assert property (!locked && !blink ##1 !locked
		|-> !lock_led)
		else $error("lock lamp steady while unlocked");

	////////////////////////////////////////////////////////////////////
	// Interrupt status: a new event wins over a clear.

	assign ev = {fw_exp && !gen_mode, locked_q && !locked,
		rng && !range_err};

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			istat <= 3'h0;
		else if (wr && addr == CFW_A_ISTAT)
			istat <= (istat & ~wdata[2:0]) | ev;
		else
			istat <= istat | ev;
	end

	assign irq = |(istat & imask);

	////////////////////////////////////////////////////////////////////
	// Register reads.

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= '0;
		else if (!rd)
			rdata <= '0;
		else
		begin
			case (addr)
				CFW_A_CTRL: rdata <= 32'(clk_ref) << CFW_F_CLK
					| 32'(pos_ref) << CFW_F_POS
					| 32'(rate_sel) << CFW_F_RATE;
				CFW_A_VSO: rdata <= 32'({1'b0, ed_cents}) << CFW_F_CENT
					| 32'({1'b0, ed_semis}) << CFW_F_SEMI
					| 32'(ed_vso) << CFW_F_VEN;
				CFW_A_PITCH: rdata <= 32'(pitch_ed);
				CFW_A_FREE:  rdata <= 32'(free_ed);
				CFW_A_RATE:  rdata <= 32'(out_rate);
				CFW_A_STATE: rdata <= 32'({pitch_hold, tc_gen_en,
					fw_st == CFW_FW_FREE, range_err, locked})
					| 32'(freewheel_length_setting) << CFW_F_FLEN;
				CFW_A_ISTAT: rdata <= 32'(istat);
				CFW_A_IMASK: rdata <= 32'(imask);
				default:     rdata <= '0;
			endcase
		end
	end
endmodule : cfw_clock_ctrl

// [rtl/cfw_pkg.sv]
/*
 Shared constants of the clock reference and freewheel controller.
 Assumes a 10 MHz clk and a plain strobe register port, byte offsets.
*/
package cfw_pkg;
	// Register byte offsets.
	localparam logic [7:0] CFW_A_CTRL  = 8'h00;
	localparam logic [7:0] CFW_A_VSO   = 8'h04;
	localparam logic [7:0] CFW_A_PITCH = 8'h08;
	localparam logic [7:0] CFW_A_FREE  = 8'h0c;
	localparam logic [7:0] CFW_A_APPLY = 8'h10;
	localparam logic [7:0] CFW_A_RATE  = 8'h14;
	localparam logic [7:0] CFW_A_STATE = 8'h18;
	localparam logic [7:0] CFW_A_ISTAT = 8'h1c;
	localparam logic [7:0] CFW_A_IMASK = 8'h20;
	// Field positions.
	localparam int CFW_F_CLK  = 0;
	localparam int CFW_F_POS  = 4;
	localparam int CFW_F_RATE = 8;
	localparam int CFW_F_CENT = 0;
	localparam int CFW_F_SEMI = 8;
	localparam int CFW_F_VEN  = 16;
	localparam int CFW_F_FLEN = 8;
	localparam int CFW_B_VSO  = 0;
	localparam int CFW_B_PHLD = 1;
	localparam int CFW_B_FREE = 2;
	localparam int CFW_B_UP   = 0;
	localparam int CFW_B_DN   = 1;
	// Clock reference and positional reference codes.
	localparam logic [2:0] CFW_CR_INT  = 3'h0;
	localparam logic [2:0] CFW_CR_LTC  = 3'h1;
	localparam logic [2:0] CFW_CR_VREF = 3'h2;
	localparam logic [2:0] CFW_CR_VIN  = 3'h3;
	localparam logic [2:0] CFW_CR_AES  = 3'h4;
	localparam logic [2:0] CFW_CR_WCLK = 3'h5;
	localparam logic [1:0] CFW_PR_GEN  = 2'h0;
	localparam logic [1:0] CFW_PR_LTC  = 2'h1;
	localparam logic [1:0] CFW_PR_VITC = 2'h2;
	localparam logic [2:0] CFW_RATE_MAX = 3'h5;
	// Nominal rates in Hz, indexed by rate select.
	localparam logic [17:0] CFW_NOM [6] = '{18'h0ac44, 18'h0bb80,
		18'h15888, 18'h17700, 18'h2b110, 18'h2ee00};
	// Varispeed limits in Hz per rate class 1x, 2x, 4x.
	localparam logic [17:0] CFW_LO [3] = '{18'h09c40, 18'h13880,
		18'h27100};
	localparam logic [17:0] CFW_HI [3] = '{18'h0c544, 18'h18a88,
		18'h31510};
	localparam logic [17:0] CFW_RATE_RST = 18'h0ac44;
	// Freewheel length limits and reset value, in frames.
	localparam logic [5:0] CFW_FW_MIN = 6'h04;
	localparam logic [5:0] CFW_FW_MAX = 6'h28;
	// Varispeed: ratio per cent scaled by two to the sixteenth.
	localparam logic signed [39:0] CFW_VSO_K = 40'sh26;
	localparam int CFW_VSO_SH = 16;
	// Lock lamp flash half period.
	localparam int CFW_CLK_HZ   = 10000000;
	localparam int CFW_BLINK_MS = 250;
	localparam int CFW_BLINK_CYC = CFW_CLK_HZ / 1000 * CFW_BLINK_MS;
	typedef enum logic [2:0] {
		CFW_FW_RUN  = 3'b001,
		CFW_FW_FREE = 3'b010,
		CFW_FW_STOP = 3'b100
	} cfw_fw_t;
endpackage : cfw_pkg

// [rtl/cfw_sync.sv]
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no bus coherence is promised.
*/
`timescale 1ns/1ps
module cfw_sync #(
	parameter int W = 1
)
(
	input  logic         clk,    // System clock.
	input  logic         resetn, // Asynchronous reset, active low.
	input  logic [W-1:0] d,      // Asynchronous levels.
	output logic [W-1:0] q       // Synchronised levels.
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : cfw_sync

// [rtl/cfw_vso_calc.sv]
/*
 Varispeed calculator: semitone and cent offsets to output rate.
 Assumes settings hold steady; result is one clock behind them.
*/
`timescale 1ns/1ps
module cfw_vso_calc
	import cfw_pkg::*;
(
	input  logic   clk,    // System clock.
	input  logic   resetn, // Asynchronous reset, active low.
	cfw_vso_if.calc vso    // Settings in, frequency out.
);
	logic signed [11:0] total;
	logic signed [39:0] prod;
	logic signed [19:0] sum;

	// A linear ratio per cent is used instead of a true exponent; over
	// three semitones the error grows to nearly two percent.
	always_comb
	begin
		total = 12'(vso.semis) * 12'sd100 + 12'(vso.cents);
		prod  = 40'(signed'({1'b0, vso.nominal})) * 40'(total) * CFW_VSO_K;
		sum   = 20'(signed'({2'b0, vso.nominal}))
			+ 20'(prod >>> CFW_VSO_SH);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			vso.freq <= CFW_RATE_RST;
		else if (sum[19])
			vso.freq <= '0;
		else
			vso.freq <= sum[17:0];
	end
endmodule : cfw_vso_calc

// [rtl/cfw_vso_if.sv]
/*
 Carrier between the controller and its varispeed calculator.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface cfw_vso_if;
	logic        [17:0] nominal;
	logic signed [2:0]  semis;
	logic signed [6:0]  cents;
	logic        [17:0] freq;
	modport ctrl (output nominal, output semis, output cents, input freq);
	modport calc (input nominal, input semis, input cents, output freq);
endinterface : cfw_vso_if

// [verification/cfw_clock_ctrl_tb.sv]
/*
 Self-checking bench of the clock reference and freewheel controller.
 Assumes cfw_ext_src stands in for every external feed.
*/
`timescale 1ns/1ps
module cfw_clock_ctrl_tb
	import cfw_pkg::*;
;
	localparam logic [31:0] NOM_HZ [6] = '{32'h0ac44, 32'h0bb80,
		32'h15888, 32'h17700, 32'h2b110, 32'h2ee00};
	localparam logic [31:0] HI_LIM [3] = '{32'h0c544, 32'h18a88, 32'h31510};
	localparam logic [31:0] LO_LIM [3] = '{32'h09c40, 32'h13880, 32'h27100};
	localparam logic [2:0]  RSEL [3]   = '{3'h0, 3'h3, 3'h5};
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        nv_pitch_hold = 1'b0;
	logic [4:0]  want = 5'h1f;
	logic [17:0] want_rate = 18'h0ac44;
	logic [31:0] rdata;
	logic [17:0] out_rate, ext_rate;
	logic        irq, nv_wr, nv_data, wclk_xtal, aes_xtal, tc_xtal;
	logic        tc_gen_en, vitc_read_en, lock_led, frame_tick;
	logic        ltc_p, vref_p, vin_p, aes_p, wclk_p;
	int          err_total = 0;
	int          n_compared = 0;
	int          cyc = 0;

	cfw_clock_ctrl #(.BLINK_CYC(4)) dut (.clk(clk), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq), .ltc_present(ltc_p), .vref_present(vref_p),
		.vin_present(vin_p), .aes_present(aes_p), .wclk_present(wclk_p),
		.nv_pitch_hold(nv_pitch_hold), .ext_rate(ext_rate),
		.frame_tick(frame_tick), .nv_wr(nv_wr), .nv_data(nv_data),
		.wclk_xtal(wclk_xtal), .aes_xtal(aes_xtal), .tc_xtal(tc_xtal),
		.out_rate(out_rate), .tc_gen_en(tc_gen_en),
		.vitc_read_en(vitc_read_en), .lock_led(lock_led));
	cfw_ext_src #(.FRAME_CYC(8)) ext (.clk(clk), .resetn(resetn),
		.want(want), .want_rate(want_rate), .ltc_present(ltc_p),
		.vref_present(vref_p), .vin_present(vin_p), .aes_present(aes_p),
		.wclk_present(wclk_p), .ext_rate(ext_rate), .frame_tick(frame_tick));

	always #50 clk = ~clk;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : go

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask : rd_chk

	task src(input logic [4:0] w, input logic [17:0] r);
		@(posedge clk);
		want      <= w;
		want_rate <= r;
	endtask : src

	task do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task lamp_tog(output int n);
		logic p;
		n = 0;
		p = lock_led;
		repeat (20)
		begin
			@(posedge clk);
			#1;
			if (lock_led !== p)
				n++;
			p = lock_led;
		end
	endtask : lamp_tog

	////////////////////////////////////////////////////////////////////
	task t_reset;
		int n;
		rd_chk(CFW_A_CTRL, '1, 32'h0);
		rd_chk(CFW_A_IMASK, '1, 32'h0);
		rd_chk(8'h24, '1, 32'h0);
		rd_chk(CFW_A_APPLY, '1, 32'h0);
		wr_reg(CFW_A_RATE, 32'h0);
		rd_chk(CFW_A_RATE, '1, 32'h0ac44);
		rd_chk(CFW_A_STATE, 32'h3f19, 32'h0409);
		chk({29'h0, wclk_xtal, aes_xtal, tc_xtal}, 32'h7);
		lamp_tog(n);
		chk(n, 0);
	endtask : t_reset

	task t_rates;
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(CFW_A_CTRL, {21'h0, 3'(i), 8'h00});
			go(2);
			rd_chk(CFW_A_RATE, '1, NOM_HZ[i]);
			chk({30'h0, wclk_xtal, aes_xtal}, 32'h3);
			chk({14'h0, out_rate}, NOM_HZ[i]);
		end
	endtask : t_rates

	task t_vso;
		wr_reg(CFW_A_CTRL, 32'h10);
		wr_reg(CFW_A_IMASK, 32'h1);
		wr_reg(CFW_A_VSO, 32'h1000a);
		rd_chk(CFW_A_RATE, '1, 32'h0ac44);
		wr_reg(CFW_A_APPLY, 32'h1);
		go(4);
		rd_chk(CFW_A_RATE, '1, 32'h0ad43);
		rd_chk(CFW_A_STATE, 32'h2, 32'h0);
		wr_reg(CFW_A_VSO, 32'h10300);
		wr_reg(CFW_A_APPLY, 32'h1);
		go(4);
		rd_chk(CFW_A_RATE, '1, 32'h0c544);
		rd_chk(CFW_A_STATE, 32'h2, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr_reg(CFW_A_ISTAT, 32'h1);
		go(2);
		chk({31'h0, irq}, 32'h0);
		wr_reg(CFW_A_VSO, 32'h1000a);
		wr_reg(CFW_A_APPLY, 32'h1);
		wr_reg(CFW_A_IMASK, 32'h0);
		wr_reg(CFW_A_VSO, 32'h10400);
		wr_reg(CFW_A_APPLY, 32'h1);
		go(4);
		rd_chk(CFW_A_ISTAT, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(CFW_A_CTRL, {21'h0, RSEL[i], 8'h10});
			wr_reg(CFW_A_VSO, 32'h10300);
			wr_reg(CFW_A_APPLY, 32'h1);
			go(4);
			rd_chk(CFW_A_RATE, '1, HI_LIM[i]);
			wr_reg(CFW_A_VSO, 32'h10400);
			wr_reg(CFW_A_APPLY, 32'h1);
			go(4);
			rd_chk(CFW_A_RATE, '1, LO_LIM[i]);
		end
		wr_reg(CFW_A_VSO, 32'h0);
		wr_reg(CFW_A_APPLY, 32'h1);
		wr_reg(CFW_A_ISTAT, 32'h7);
	endtask : t_vso

	task t_pitch;
		logic seen;
		int   n;
		seen = 1'b0;
		wr_reg(CFW_A_CTRL, 32'h4);
		src(5'h02, 18'h0b798);
		go(6);
		rd_chk(CFW_A_RATE, '1, 32'h0b798);
		chk({29'h0, wclk_xtal, aes_xtal, tc_xtal}, 32'h0);
		wr_reg(CFW_A_PITCH, 32'h1);
		wr_reg(CFW_A_APPLY, 32'h2);
		repeat (4)
		begin
			#1;
			seen = seen | (nv_wr & nv_data);
			@(posedge clk);
		end
		chk({31'h0, seen}, 32'h1);
		src(5'h00, 18'h0b798);
		go(8);
		rd_chk(CFW_A_RATE, '1, 32'h0b798);
		rd_chk(CFW_A_ISTAT, 32'h2, 32'h2);
		lamp_tog(n);
		chk(32'(n >= 2), 32'h1);
		wr_reg(CFW_A_PITCH, 32'h0);
		wr_reg(CFW_A_APPLY, 32'h2);
		src(5'h02, 18'h0ea60);
		go(6);
		rd_chk(CFW_A_RATE, '1, 32'h0c544);
		src(5'h00, 18'h0ea60);
		go(6);
		rd_chk(CFW_A_RATE, '1, 32'h0ac44);
		rd_chk(CFW_A_STATE, 32'h1, 32'h0);
	endtask : t_pitch

	task t_free;
		int   n;
		logic g;
		n = 0;
		g = 1'b1;
		wr_reg(CFW_A_CTRL, 32'h10);
		src(5'h10, 18'h0ac44);
		wr_reg(CFW_A_FREE, 32'h2);
		rd_chk(CFW_A_FREE, 32'h3f, 32'h4);
		repeat (37) wr_reg(CFW_A_FREE, 32'h1);
		rd_chk(CFW_A_FREE, 32'h3f, 32'h28);
		rd_chk(CFW_A_STATE, 32'h3f00, 32'h0400);
		wr_reg(CFW_A_APPLY, 32'h4);
		rd_chk(CFW_A_STATE, 32'h3f00, 32'h2800);
		repeat (36) wr_reg(CFW_A_FREE, 32'h2);
		wr_reg(CFW_A_APPLY, 32'h4);
		rd_chk(CFW_A_STATE, 32'h3f00, 32'h0400);
		src(5'h00, 18'h0ac44);
		for (int c = 0; c < 80 && tc_gen_en !== 1'b0; c++)
		begin
			@(posedge clk);
			#1;
			if (frame_tick === 1'b1)
				n++;
		end
		chk({31'h0, tc_gen_en}, 32'h0);
		chk(32'(n >= 4 && n <= 5), 32'h1);
		rd_chk(CFW_A_ISTAT, 32'h4, 32'h4);
		src(5'h10, 18'h0ac44);
		go(6);
		chk({31'h0, tc_gen_en}, 32'h1);
		src(5'h00, 18'h0ac44);
		repeat (12)
		begin
			@(posedge clk);
			#1;
			g = g & tc_gen_en;
		end
		src(5'h10, 18'h0ac44);
		go(6);
		chk({31'h0, g & tc_gen_en}, 32'h1);
		wr_reg(CFW_A_CTRL, 32'h0);
		src(5'h00, 18'h0ac44);
		repeat (60)
		begin
			@(posedge clk);
			#1;
			g = g & tc_gen_en & tc_xtal;
		end
		chk({31'h0, g}, 32'h1);
	endtask : t_free

	task t_video;
		wr_reg(CFW_A_CTRL, 32'h22);
		src(5'h0c, 18'h0ac44);
		go(6);
		chk({31'h0, vitc_read_en}, 32'h1);
		src(5'h08, 18'h0ac44);
		go(6);
		rd_chk(CFW_A_STATE, 32'h1, 32'h1);
		chk({31'h0, vitc_read_en}, 32'h0);
		wr_reg(CFW_A_CTRL, 32'h111);
		src(5'h10, 18'h0bb80);
		go(6);
		rd_chk(CFW_A_RATE, '1, 32'h0bb80);
		rd_chk(CFW_A_STATE, 32'h9, 32'h9);
		wr_reg(CFW_A_CTRL, 32'h5);
		src(5'h01, 18'h0bb80);
		go(6);
		rd_chk(CFW_A_RATE, '1, 32'h0bb80);
		wr_reg(CFW_A_CTRL, 32'h3);
		src(5'h04, 18'h0bb80);
		go(6);
		rd_chk(CFW_A_STATE, 32'h1, 32'h1);
		wr_reg(CFW_A_CTRL, 32'h33);
		go(2);
		rd_chk(CFW_A_STATE, 32'h1, 32'h0);
	endtask : t_video

	task t_nv;
		@(posedge clk);
		nv_pitch_hold <= 1'b1;
		do_reset();
		rd_chk(CFW_A_STATE, 32'h10, 32'h10);
	endtask : t_nv

	initial
	begin
		do_reset();
		t_reset();
		t_rates();
		t_vso();
		t_pitch();
		t_free();
		t_video();
		t_nv();
		tally_and_finish();
	end
endmodule : cfw_clock_ctrl_tb

// [verification/cfw_ext_src.sv]
/*
 Model of the far side: transports, video feeds and clock feeds.
 Assumes the bench asks for feeds by level; one frame per FRAME_CYC.
*/
`timescale 1ns/1ps
module cfw_ext_src #(
	parameter int FRAME_CYC = 8 // Clock cycles per frame.
)
(
	input  logic        clk,          // System clock.
	input  logic        resetn,       // Asynchronous reset, active low.
	input  logic [4:0]  want,         // Feeds: ltc, vref, vin, aes, wclk.
	input  logic [17:0] want_rate,    // Rate of the external feed, Hz.
	output logic        ltc_present,  // LTC feed present.
	output logic        vref_present, // Black burst on reference input.
	output logic        vin_present,  // Picture on video input.
	output logic        aes_present,  // AES feed present.
	output logic        wclk_present, // Word clock feed present.
	output logic [17:0] ext_rate,     // Measured feed rate.
	output logic        frame_tick    // One pulse per frame.
);
	int         frame_cnt;
	logic [2:0] live;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{ltc_present, aes_present, wclk_present} <= 3'h0;
			{vref_present, vin_present} <= 2'h0;
		end
		else
		begin
			{ltc_present, aes_present, wclk_present} <= {want[4], want[1:0]};
			// Striped picture feeds video in; burst feeds only the ref.
			{vref_present, vin_present} <= want[3:2];
		end
	end

	// The meter keeps its last reading a little longer than the presence
	// detectors take to report a loss; after that it churns, so a stale
	// rate cannot pass.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			live     <= 3'h0;
			ext_rate <= 18'h0;
		end
		else
		begin
			live     <= {live[1:0], |want};
			ext_rate <= (|want || |live) ? want_rate : ~ext_rate;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			frame_cnt  <= 0;
			frame_tick <= 1'b0;
		end
		else
		begin
			frame_cnt  <= (frame_cnt == FRAME_CYC - 1) ? 0 : frame_cnt + 1;
			frame_tick <= (frame_cnt == FRAME_CYC - 1);
		end
	end
endmodule : cfw_ext_src
